// ---- rtl/pciu_pkg.sv ----
// Shared constants and types of the pin change interrupt unit
package pciu_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_FLAG = 8'h3b;
  localparam logic [7:0] IDX_CTRL = 8'h68;
  localparam logic [7:0] IDX_MASK_B = 8'h6b;
  localparam logic [7:0] IDX_MASK_C = 8'h6c;
  localparam logic [7:0] IDX_MASK_D = 8'h6d;
  localparam logic [7:0] IDX_MASK_E = 8'h73;
  localparam logic [7:0] IDX_EVT_STAT = 8'h80;
  localparam logic [7:0] IDX_EVT_EN = 8'h81;
  localparam logic [7:0] IDX_EVT_CLR = 8'h82;

  // Layout: group n sits in bit n of control, flag and event registers
  localparam int GROUPS = 4;
  localparam int PINS_PER_GROUP = 8;
  localparam int GROUP_LSB = 0;
  localparam int GROUP_MSB = 3;

  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [3:0] FLAG_RST = 4'h0;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [3:0] EVT_RST = 4'h0;

  // Pins that exist per group (E, D, C, B); bit 7 of C and E is reserved
  localparam logic [3:0][7:0] PIN_IMPL = {8'h7f, 8'hff, 8'h7f, 8'hff};

  // Pin synchroniser depth and the settling time before changes count
  localparam int SYNC_STAGES = 3;
  localparam logic [1:0] ARM_CYCLES = 2'h3;

  // AHB transfer encodings used by the slave
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Pad levels of the four ports, port B in the low byte
  typedef struct packed {
    logic [7:0] portE;
    logic [7:0] portD;
    logic [7:0] portC;
    logic [7:0] portB;
  } pciu_pins_t;

  // Complete state of the unit
  typedef struct packed {
    logic [3:0][7:0] sync1;
    logic [3:0][7:0] sync2;
    logic [3:0][7:0] sync3;
    logic [3:0][7:0] level;
    logic [1:0] armCnt;
    logic [3:0][7:0] mask;
    logic [3:0] ctrl;
    logic [3:0] flag;
    logic [3:0] evtStat;
    logic [3:0] evtEn;
    logic wrPend;
    logic [7:0] wrIdx;
    logic [31:0] rdata;
  } pciu_state_t;

endpackage : pciu_pkg

// ---- rtl/pciu_top.sv ----
// Operation
// RL1: Control register bits 3..0 enable groups E, D, C and B.
// RL2: A group request needs its enable bit and the global enable.
// RL3: With its enable bit clear a group never requests, whatever else.
// RL4: A change on a masked-in pin sets its group flag, B=0 to E=3.
// RL5: Flag, group enable and global enable together request that entry.
// RL6: Servicing a group's interrupt clears that group's flag.
// RL7: Writing 1 to a flag bit clears it; writing 0 leaves it.
// RL8: Flag register holds flags in bits 3..0; bits 7..4 read zero.
// RL9: Port B mask: bit n enables change detection on port B pin n.
// RL10: Port C mask: bits 6..0 enable port C pins; bit 7 reserved.
// RL11: A pin whose mask bit is 0 never sets its group flag.
// RL12: Pins driven as outputs are still watched, giving software interrupts.
// RL13: Pin changes are seen without a clock, as a wake-up source.
// RL14: Port D mask: bit n enables port D pin n, setting flag 2.
// RL15: Port E mask: bits 6..0 enable port E pins; bit 7 reserved.
// RL16: Pins are synchronised and compared with their previous sample.
// RL17: A new change beats a clear of the same flag in one cycle.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module pciu_top #(
  parameter int ADDR_W = 12,
  parameter int PIN_W = pciu_pkg::PINS_PER_GROUP
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire pciu_pkg::pciu_pins_t pinsIn,
  input wire logic globalIrqEn,
  input wire logic [3:0] groupAck,
  output logic [3:0] groupIrq,
  output logic pinWake,
  output logic irq
);

  // Refuse geometries the register layout cannot carry
  if (PIN_W != pciu_pkg::PINS_PER_GROUP) begin : gPinCheck
    $error("pciu_top: PIN_W must equal eight");
  end
  if (ADDR_W < 10) begin : gAddrCheck
    $error("pciu_top: ADDR_W too small for the register map");
  end

  // Reset release through two flops; assertion stays asynchronous
  logic rstSync1_q;
  logic rstSyncN_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1_q <= 1'b0;
      rstSyncN_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSyncN_q <= rstSync1_q;
    end
  end

  pciu_pkg::pciu_state_t st_q;
  pciu_pkg::pciu_state_t st_d;

  // Pads viewed as one byte lane per group, group 0 = port B
  logic [3:0][7:0] pinArr;
  assign pinArr = pinsIn;

  logic armed;
  assign armed = (st_q.armCnt == pciu_pkg::ARM_CYCLES);

  // Per-group filtering, change detection and clockless wake path
  logic [3:0][7:0] levelNext;
  logic [3:0] groupChange;
  logic [3:0] groupWake;
  for (genvar g = 0; g < pciu_pkg::GROUPS; g++) begin : gGroup
    logic [7:0] agree;
    logic [7:0] diff;
    // A pin moves only once the second and third stages agree
    assign agree = ~(st_q.sync2[g] ^ st_q.sync3[g]);
    assign levelNext[g] = (agree & st_q.sync3[g]) |
                          (~agree & st_q.level[g]); // [RL16]
    // Output pins are read back from the pad like inputs
    assign diff = levelNext[g] ^ st_q.level[g]; // [RL12]
    // Only masked-in pins may raise the group flag
    assign groupChange[g] = armed & (|(diff & st_q.mask[g])); // [RL4] [RL11]
    // Raw pad against last level, no clock edge needed to see it
    assign groupWake[g] = |((pinArr[g] ^ st_q.level[g]) &
                            st_q.mask[g]); // [RL13]
  end

  // Asynchronous wake request, ignored until the levels have settled
  assign pinWake = armed & (|groupWake); // [RL13]

  // Address phase taken when the slave is selected and the bus is ready
  logic addrPhase;
  logic [7:0] addrIdx;
  assign addrPhase = hsel & hready & (htrans == pciu_pkg::HTRANS_NONSEQ);
  assign addrIdx = haddr[9:2];

  // Decoded data-phase write strobes
  logic wrCtrl;
  logic wrFlag;
  logic wrMaskB;
  logic wrMaskC;
  logic wrMaskD;
  logic wrMaskE;
  logic wrEvtEn;
  logic wrEvtClr;
  assign wrCtrl = st_q.wrPend & (st_q.wrIdx == pciu_pkg::IDX_CTRL);
  assign wrFlag = st_q.wrPend & (st_q.wrIdx == pciu_pkg::IDX_FLAG);
  assign wrMaskB = st_q.wrPend & (st_q.wrIdx == pciu_pkg::IDX_MASK_B);
  assign wrMaskC = st_q.wrPend & (st_q.wrIdx == pciu_pkg::IDX_MASK_C);
  assign wrMaskD = st_q.wrPend & (st_q.wrIdx == pciu_pkg::IDX_MASK_D);
  assign wrMaskE = st_q.wrPend & (st_q.wrIdx == pciu_pkg::IDX_MASK_E);
  assign wrEvtEn = st_q.wrPend & (st_q.wrIdx == pciu_pkg::IDX_EVT_EN);
  assign wrEvtClr = st_q.wrPend & (st_q.wrIdx == pciu_pkg::IDX_EVT_CLR);

  // Flag clears from software and from interrupt service
  logic [3:0] flagSwClr;
  logic [3:0] flagClr;
  logic [3:0] evtClr;
  assign flagSwClr = wrFlag ? hwdata[3:0] : 4'h0; // [RL7]
  assign flagClr = flagSwClr | groupAck; // [RL6]
  assign evtClr = wrEvtClr ? hwdata[3:0] : 4'h0;

  // Next state of the whole unit
  always_comb begin
    st_d = st_q;

    // Three-stage pad synchroniser and filtered levels
    st_d.sync1 = pinArr;
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    st_d.level = levelNext;

    // Hold off change reporting until the pipeline holds real samples
    if (!armed) begin
      st_d.armCnt = st_q.armCnt + 2'h1;
    end

    // Register writes land in the data phase; reserved bits are dropped
    if (wrCtrl) begin
      st_d.ctrl = hwdata[pciu_pkg::GROUP_MSB:pciu_pkg::GROUP_LSB]; // [RL1]
    end
    if (wrMaskB) begin
      st_d.mask[0] = hwdata[7:0] & pciu_pkg::PIN_IMPL[0]; // [RL9]
    end
    if (wrMaskC) begin
      st_d.mask[1] = hwdata[7:0] & pciu_pkg::PIN_IMPL[1]; // [RL10]
    end
    if (wrMaskD) begin
      st_d.mask[2] = hwdata[7:0] & pciu_pkg::PIN_IMPL[2]; // [RL14]
    end
    if (wrMaskE) begin
      st_d.mask[3] = hwdata[7:0] & pciu_pkg::PIN_IMPL[3]; // [RL15]
    end
    if (wrEvtEn) begin
      st_d.evtEn = hwdata[3:0];
    end

    // Set wins over clear so a change in the clearing cycle survives
    st_d.flag = (st_q.flag & ~flagClr) | groupChange; // [RL4] [RL17]
    st_d.evtStat = (st_q.evtStat & ~evtClr) | groupChange; // [RL17]

    // A write occupies one data phase only
    st_d.wrPend = 1'b0;
    st_d.rdata = 32'h0000_0000;
    if (addrPhase) begin
      st_d.wrPend = hwrite & (hsize == pciu_pkg::HSIZE_WORD);
      st_d.wrIdx = addrIdx;
    end

    // Read data taken from the next state so a write just ahead shows
    if (addrPhase && !hwrite) begin
      unique case (addrIdx)
        pciu_pkg::IDX_CTRL: begin
          st_d.rdata = {28'h0000000, st_d.ctrl};
        end
        pciu_pkg::IDX_FLAG: begin
          st_d.rdata = {28'h0000000, st_d.flag}; // [RL8]
        end
        pciu_pkg::IDX_MASK_B: begin
          st_d.rdata = {24'h000000, st_d.mask[0]};
        end
        pciu_pkg::IDX_MASK_C: begin
          st_d.rdata = {24'h000000, st_d.mask[1]};
        end
        pciu_pkg::IDX_MASK_D: begin
          st_d.rdata = {24'h000000, st_d.mask[2]};
        end
        pciu_pkg::IDX_MASK_E: begin
          st_d.rdata = {24'h000000, st_d.mask[3]};
        end
        pciu_pkg::IDX_EVT_STAT: begin
          st_d.rdata = {28'h0000000, st_d.evtStat};
        end
        pciu_pkg::IDX_EVT_EN: begin
          st_d.rdata = {28'h0000000, st_d.evtEn};
        end
        default: begin
          // Clear register and unmapped words read as zero
          st_d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // State register on the synchronised reset
  always_ff @(posedge ref_clk or negedge rstSyncN_q) begin
    if (!rstSyncN_q) begin
      st_q.sync1 <= '0;
      st_q.sync2 <= '0;
      st_q.sync3 <= '0;
      st_q.level <= '0;
      st_q.armCnt <= 2'h0;
      st_q.mask <= {4{pciu_pkg::MASK_RST}};
      st_q.ctrl <= pciu_pkg::CTRL_RST;
      st_q.flag <= pciu_pkg::FLAG_RST;
      st_q.evtStat <= pciu_pkg::EVT_RST;
      st_q.evtEn <= pciu_pkg::EVT_RST;
      st_q.wrPend <= 1'b0;
      st_q.wrIdx <= 8'h00;
      st_q.rdata <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  // Vector request: flag gated by group enable and the core's global enable
  assign groupIrq = st_q.flag & st_q.ctrl &
                    {4{globalIrqEn}}; // [RL2] [RL3] [RL5]

  // Level interrupt from enabled sticky event bits
  assign irq = |(st_q.evtStat & st_q.evtEn);

  // Zero-wait slave that always answers OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_q.rdata;

endmodule : pciu_top

// ---- tb/pciu_asserts.sv ----
`timescale 1ns/1ps

module pciu_asserts (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire pciu_pkg::pciu_pins_t pinsIn,
  input wire logic globalIrqEn,
  input wire logic [3:0] groupAck,
  input wire logic [3:0] groupIrq,
  input wire logic pinWake
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Pads unchanged long enough that no change is still in the pipe
  sequence s_pins_still;
    $stable(pinsIn)[*5];
  endsequence
  // Nothing that may move a flag or an enable for five samples
  sequence s_quiet;
    ($stable(pinsIn) && !hsel && groupAck == 4'h0
      && $stable(globalIrqEn))[*5];
  endsequence
  a_irq_steady: assert property (s_quiet |=> $stable(groupIrq))
    else $error("group request moved without a cause");
  a_ack_clears: assert property (s_pins_still ##0 groupAck != 4'h0
    |=> (groupIrq & $past(groupAck)) == 4'h0)
    else $error("serviced group still requesting");
  a_wake_quiet: assert property ($stable(pinsIn)[*8] |-> !pinWake)
    else $error("wake raised with settled pads");
  a_global_gate: assert property (!globalIrqEn |-> groupIrq == 4'h0)
    else $error("group request without global enable");
  a_global_fall: assert property ($fell(globalIrqEn) |-> !(|groupIrq))
    else $error("group request kept after global disable");
  a_reserved_zero: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_no_wait: assert property (hreadyout == 1'b1)
    else $error("slave inserted a wait");
endmodule : pciu_asserts

bind pciu_top pciu_asserts pciu_asserts_inst (
  .ref_clk(ref_clk),
  .rstn(rstn),
  .hsel(hsel),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .pinsIn(pinsIn),
  .globalIrqEn(globalIrqEn),
  .groupAck(groupAck),
  .groupIrq(groupIrq),
  .pinWake(pinWake)
);

// ---- tb/pciu_core_model.sv ----
`timescale 1ns/1ps

module pciu_core_model (
  input wire logic ref_clk,
  input wire logic svcOn,
  input wire logic [3:0] groupIrq,
  output logic [3:0] groupAck = 4'h0
);
  // Core enters the lowest pending entry; a gap after each ack
  always @(posedge ref_clk) begin
    if (svcOn && groupAck == 4'h0) begin
      groupAck <= groupIrq & (~groupIrq + 4'h1);
    end else begin
      groupAck <= 4'h0;
    end
  end
endmodule : pciu_core_model

// ---- tb/pin_change_interrupt_unit_bench.sv ----
`timescale 1ns/1ps

module pin_change_interrupt_unit_bench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, pinWake, irq;
  logic [31:0] hrdata, rv;
  logic [3:0] groupAck, groupIrq;
  pciu_pkg::pciu_pins_t pinsIn = '0;
  logic globalIrqEn = 1'b0;
  logic svcOn = 1'b0;
  int fails = 0;
  int check_count = 0;
  // Registers in order, with the value read back after writing 0xff
  logic [7:0] regIdx [7] = '{pciu_pkg::IDX_FLAG, pciu_pkg::IDX_CTRL,
    pciu_pkg::IDX_MASK_B, pciu_pkg::IDX_MASK_C, pciu_pkg::IDX_MASK_D,
    pciu_pkg::IDX_MASK_E, 8'h7f};
  logic [31:0] regWid [7] = '{32'h0, 32'hf, 32'hff, 32'h7f, 32'hff,
    32'h7f, 32'h0};

  pciu_top pciu_top_inst (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(pciu_pkg::HSIZE_WORD),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .pinsIn(pinsIn),
    .globalIrqEn(globalIrqEn),
    .groupAck(groupAck),
    .groupIrq(groupIrq),
    .pinWake(pinWake),
    .irq(irq)
  );

  pciu_core_model pciu_core_model_inst (
    .ref_clk(ref_clk),
    .svcOn(svcOn),
    .groupIrq(groupIrq),
    .groupAck(groupAck)
  );

  // 25 MHz clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // Single word transfer; each phase held until ready is sampled high
  task automatic bus(input logic [7:0] idx, input logic wr,
      input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {2'h0, idx, 2'h0};
    htrans <= pciu_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : bus

  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    bus(idx, 1'b0, 32'h0);
    chk($sformatf("reg %h", idx), e, rv);
  endtask : rd

  // Toggle one pad, then let the synchroniser settle; w is the wake expected
  task automatic flip(input int b, input logic w);
    @(posedge ref_clk);
    pinsIn[b] <= ~pinsIn[b];
    #1 chk("pinWake", {31'h0, w}, {31'h0, pinWake});
    repeat (6) @(posedge ref_clk);
  endtask : flip

  task automatic final_report;
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // Main sequence of register, pin and service checks
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    foreach (regIdx[i]) begin
      rd(regIdx[i], 32'h0);
      bus(regIdx[i], 1'b1, 32'hff);
      rd(regIdx[i], regWid[i]);
    end
    globalIrqEn <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      flip(g * 8, 1'b1);
      rd(pciu_pkg::IDX_FLAG, 32'h1 << g);
      chk("groupIrq", 32'h1 << g, {28'h0, groupIrq});
      bus(pciu_pkg::IDX_FLAG, 1'b1, 32'h0);
      rd(pciu_pkg::IDX_FLAG, 32'h1 << g);
      bus(pciu_pkg::IDX_FLAG, 1'b1, 32'h1 << g);
      rd(pciu_pkg::IDX_FLAG, 32'h0);
    end
    // Event status: raise, mask, clear
    rd(pciu_pkg::IDX_EVT_STAT, 32'hf);
    bus(pciu_pkg::IDX_EVT_EN, 1'b1, 32'h4);
    #1 chk("irq", 32'h1, {31'h0, irq});
    bus(pciu_pkg::IDX_EVT_EN, 1'b1, 32'h0);
    #1 chk("irq", 32'h0, {31'h0, irq});
    bus(pciu_pkg::IDX_EVT_EN, 1'b1, 32'h4);
    bus(pciu_pkg::IDX_EVT_CLR, 1'b1, 32'hf);
    #1 chk("irq", 32'h0, {31'h0, irq});
    rd(pciu_pkg::IDX_EVT_STAT, 32'h0);
    rd(pciu_pkg::IDX_EVT_CLR, 32'h0);
    // Masked-out pin and reserved port C pin never set a flag
    bus(pciu_pkg::IDX_MASK_B, 1'b1, 32'h1);
    flip(1, 1'b0);
    pinsIn[15] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(pciu_pkg::IDX_FLAG, 32'h0);
    // Group disabled, then global disabled, then both on
    bus(pciu_pkg::IDX_CTRL, 1'b1, 32'h0);
    flip(0, 1'b1);
    rd(pciu_pkg::IDX_FLAG, 32'h1);
    chk("groupIrq", 32'h0, {28'h0, groupIrq});
    globalIrqEn <= 1'b0;
    bus(pciu_pkg::IDX_CTRL, 1'b1, 32'h1);
    #1 chk("groupIrq", 32'h0, {28'h0, groupIrq});
    @(posedge ref_clk);
    globalIrqEn <= 1'b1;
    #1 chk("groupIrq", 32'h1, {28'h0, groupIrq});
    svcOn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(pciu_pkg::IDX_FLAG, 32'h0);
    final_report();
  end

  // The whole run needs well under 1500 cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    final_report();
  end
endmodule : pin_change_interrupt_unit_bench
